// *** rtl/scs_pkg.sv ***
// constants and types shared by the conversion sequencer files
package scs_pkg;

  // ********************************************************
  // resolution and codes
  // ********************************************************
  localparam int          RES_BITS  = 16;
  localparam logic [15:0] MIDSCALE  = 16'h8000;
  localparam logic [15:0] SIGN_MASK = 16'h8000;
  localparam logic [15:0] CODE_ZERO = 16'h0000;

  // ********************************************************
  // clock and timing
  // ********************************************************
  localparam int CLK_FREQ_HZ     = 10_000_000;
  localparam int FAST_RATE_SPS   = 570_000;
  localparam int NORMAL_RATE_SPS = 500_000;
  // least conversion periods, rounded up to whole cycles
  localparam int FAST_PERIOD_CYC =
    (CLK_FREQ_HZ + FAST_RATE_SPS - 1) / FAST_RATE_SPS;
  localparam int NORMAL_PERIOD_CYC =
    (CLK_FREQ_HZ + NORMAL_RATE_SPS - 1) / NORMAL_RATE_SPS;
  // extra acquisition for normal mode, normal period less fast period
  localparam logic [7:0] NORMAL_ACQ_MIN =
    8'(NORMAL_PERIOD_CYC - FAST_PERIOD_CYC);
  localparam logic [7:0] ACQ_MIN   = 8'h01;
  localparam int GAP_LIMIT_US      = 1000;
  // longest gap, rounded down
  localparam int GAP_LIMIT_CYC = GAP_LIMIT_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int STEP_DIV          = 1;

  // ********************************************************
  // register map and fields
  // ********************************************************
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h4;
  localparam logic [3:0] REG_RESULT   = 4'h8;
  localparam logic [7:0] CTRL_ACQ_RST = 8'h01;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_STATE_LSB = 1;
  localparam int ST_STALE_BIT = 3;
  localparam int ST_PD_BIT    = 4;

  // ********************************************************
  // sequencer states, gray along idle-conv-acq-pdown-idle
  // ********************************************************
  typedef enum logic [1:0] {
    SCS_IDLE  = 2'b00,
    SCS_CONV  = 2'b01,
    SCS_ACQ   = 2'b11,
    SCS_PDOWN = 2'b10
  } scs_state_e;

endpackage

// *** rtl/scs_sar_if.sv ***
// link between the sequencer and its approximation engine
`timescale 1ns/1ps
interface scs_sar_if;
  logic        start;
  logic        step_en;
  logic        cmp;
  logic [15:0] trial;
  logic [15:0] result;
  logic        done;

  // sequencer side
  modport ctrl (output start, step_en, cmp, input trial, result, done);
  // engine side
  modport engine (input start, step_en, cmp, output trial, result, done);
endinterface

// *** rtl/scs_sar_engine.sv ***
// successive approximation engine: one trial bit per step, msb first
`timescale 1ns/1ps
module scs_sar_engine (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link to the sequencer
  scs_sar_if.engine sar
);

  logic [15:0] trial_q, trial_d;
  logic [15:0] bit_q, bit_d;
  logic [15:0] res_q, res_d;
  logic        act_q, act_d;
  logic        done_q, done_d;
  logic [4:0]  steps_q, steps_d;
  logic [15:0] keep;

  // ********************************************************
  // binary search
  // ********************************************************
  // a comparator high keeps the trial bit; saturation at either end of
  // the span falls out of the search itself
  always_comb begin
    trial_d = trial_q;
    bit_d   = bit_q;
    res_d   = res_q;
    act_d   = act_q;
    done_d  = 1'b0;
    steps_d = steps_q;
    keep    = sar.cmp ? trial_q : (trial_q & ~bit_q);
    if (sar.start) begin
      trial_d = scs_pkg::MIDSCALE;
      bit_d   = scs_pkg::MIDSCALE;
      act_d   = 1'b1;
      steps_d = 5'h00;
    end else if (act_q && sar.step_en) begin
      steps_d = steps_q + 5'h01;
      if (bit_q[0]) begin
        res_d   = keep;
        trial_d = keep;
        act_d   = 1'b0;
        done_d  = 1'b1;
      end else begin
        trial_d = keep | (bit_q >> 1);
        bit_d   = bit_q >> 1;
      end
    end
  end

  // state registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trial_q <= scs_pkg::CODE_ZERO;
      bit_q   <= scs_pkg::CODE_ZERO;
      res_q   <= scs_pkg::CODE_ZERO;
      act_q   <= 1'b0;
      done_q  <= 1'b0;
      steps_q <= 5'h00;
    end else begin
      trial_q <= trial_d;
      bit_q   <= bit_d;
      res_q   <= res_d;
      act_q   <= act_d;
      done_q  <= done_d;
      steps_q <= steps_d;
    end
  end

  assign sar.trial  = trial_q;
  assign sar.result = res_q;
  assign sar.done   = done_q;

  // ********************************************************
  // checks
  // ********************************************************
  property p_sixteen_steps;
    @(posedge ref_clk) disable iff (!rst_n)
      sar.done |-> steps_q == 5'd16;
  endproperty
  a_sixteen_steps: assert property (p_sixteen_steps)
    else $error("result not formed after sixteen steps");

  property p_msb_first;
    @(posedge ref_clk) disable iff (!rst_n)
      sar.start |=> (trial_q == 16'h8000) && act_q;
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("search did not begin at the msb");

endmodule // scs_sar_engine

// *** rtl/scs_sequencer.sv ***
// conversion sequencer for a 16-bit successive approximation converter
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module scs_sequencer #(
  parameter int GAP_LIMIT_CYC = scs_pkg::GAP_LIMIT_CYC,
  parameter int STEP_DIV      = scs_pkg::STEP_DIV
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // host control pins
  input  wire logic        convert_start_n,
  input  wire logic        reset_in,
  input  wire logic        power_down_in,
  input  wire logic        output_coding_select,
  input  wire logic        mode_fast_sel,
  input  wire logic        mode_burst_sel,
  // analog front end
  input  wire logic        cmp_in,
  output logic [15:0]      dac_trial,
  output logic             sample_hold,
  output logic             analog_power_en,
  // conversion results
  output logic             busy,
  output logic [15:0]      data_out,
  output logic             data_stale,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wr_data,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  output logic [31:0]      reg_rd_data
);

  localparam int GW = $clog2(GAP_LIMIT_CYC + 2);

  scs_sar_if sar ();

  scs_pkg::scs_state_e st_q, st_d;
  logic          start_prev_q;
  logic          busy_q, busy_d;
  logic [7:0]    acq_q, acq_d;
  logic [15:0]   data_q, data_d;
  logic          stale_q, stale_d;
  logic          stale_pend_q, stale_pend_d;
  logic [GW-1:0] gap_q, gap_d;
  logic          first_q, first_d;
  logic          pwr_q, pwr_d;
  logic [3:0]    div_q, div_d;
  logic [7:0]    ctrl_acq_q, ctrl_acq_d;
  logic [31:0]   rd_q, rd_d;
  logic          fall;
  logic          burst;
  logic [7:0]    acq_len;
  logic [15:0]   coded;
  logic          go;

  // ********************************************************
  // start detection and mode decode
  // ********************************************************
  // burst only counts with the fast select low
  assign fall    = start_prev_q & ~convert_start_n;
  assign burst   = mode_burst_sel & ~mode_fast_sel;
  // normal mode stretches acquisition to at least NORMAL_ACQ_MIN; a start edge
  // during acquisition still launches at once; fast mode takes what software asks, at least one cycle
  assign acq_len = (!mode_fast_sel && !burst &&
                    ctrl_acq_q < scs_pkg::NORMAL_ACQ_MIN) ?
                   scs_pkg::NORMAL_ACQ_MIN :
                   (ctrl_acq_q == 8'h00 ? scs_pkg::ACQ_MIN : ctrl_acq_q);
  // msb inverted for twos complement
  assign coded   = sar.result ^
                   (scs_pkg::SIGN_MASK & {16{~output_coding_select}});

  // edge history sampled every cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_prev_q <= 1'b1;
    end else begin
      start_prev_q <= convert_start_n;
    end
  end

  // ********************************************************
  // sequencer
  // ********************************************************
  always_comb begin
    st_d         = st_q;
    busy_d       = busy_q;
    acq_d        = acq_q;
    data_d       = data_q;
    stale_d      = stale_q;
    stale_pend_d = stale_pend_q;
    go           = 1'b0;
    unique case (st_q)
      scs_pkg::SCS_IDLE: begin
        if (power_down_in) begin
          st_d = scs_pkg::SCS_PDOWN;
        end else if (fall) begin
          go = 1'b1;
        end
      end
      scs_pkg::SCS_CONV: begin
        // start edges here are dropped on purpose
        if (sar.done) begin
          data_d  = coded;
          stale_d = stale_pend_q;
          busy_d  = 1'b0;
          acq_d   = acq_len;
          st_d    = power_down_in ? scs_pkg::SCS_PDOWN
                                  : scs_pkg::SCS_ACQ;
        end
      end
      scs_pkg::SCS_ACQ: begin
        if (acq_q != 8'h00) begin
          acq_d = acq_q - 8'h01;
        end
        if (power_down_in) begin
          st_d = scs_pkg::SCS_PDOWN;
        end else if (burst) begin
          // held start low at the end re-triggers at once
          if (acq_q == 8'h00) begin
            if (!convert_start_n) begin
              go = 1'b1;
            end else begin
              st_d = scs_pkg::SCS_IDLE;
            end
          end
        end else if (fall) begin
          go = 1'b1;
        end else if (acq_q == 8'h00) begin
          st_d = scs_pkg::SCS_IDLE;
        end
      end
      scs_pkg::SCS_PDOWN: begin
        // front end must reacquire after waking
        if (!power_down_in) begin
          st_d  = scs_pkg::SCS_ACQ;
          acq_d = acq_len;
        end
      end
    endcase
    if (go) begin
      st_d         = scs_pkg::SCS_CONV;
      busy_d       = 1'b1;
      // fast mode after a long gap or power-up is flagged
      stale_pend_d = mode_fast_sel &&
                     (first_q || gap_q > GW'(GAP_LIMIT_CYC));
    end
    if (reset_in) begin
      st_d         = scs_pkg::SCS_IDLE;
      busy_d       = 1'b0;
      acq_d        = 8'h00;
      stale_pend_d = 1'b0;
      go           = 1'b0;
    end
  end

  // gap timer, power control and step divider
  // the gap timer saturates just past the limit so it never wraps
  always_comb begin
    gap_d   = gap_q;
    first_d = first_q;
    div_d   = 4'h0;
    if (go) begin
      gap_d   = '0;
      first_d = 1'b0;
    end else if (gap_q <= GW'(GAP_LIMIT_CYC)) begin
      gap_d = gap_q + GW'(1);
    end
    if (reset_in) begin
      first_d = 1'b1;
    end
    if (st_q == scs_pkg::SCS_CONV && div_q != 4'(STEP_DIV - 1)) begin
      div_d = div_q + 4'h1;
    end
    // burst mode sleeps whenever idle
    pwr_d = (st_d != scs_pkg::SCS_PDOWN) &&
            !(burst && st_d == scs_pkg::SCS_IDLE);
  end

  // sequencer registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q         <= scs_pkg::SCS_IDLE;
      busy_q       <= 1'b0;
      acq_q        <= 8'h00;
      data_q       <= scs_pkg::CODE_ZERO;
      stale_q      <= 1'b0;
      stale_pend_q <= 1'b0;
      gap_q        <= '0;
      first_q      <= 1'b1;
      pwr_q        <= 1'b0;
      div_q        <= 4'h0;
    end else begin
      st_q         <= st_d;
      busy_q       <= busy_d;
      acq_q        <= acq_d;
      data_q       <= data_d;
      stale_q      <= stale_d;
      stale_pend_q <= stale_pend_d;
      gap_q        <= gap_d;
      first_q      <= first_d;
      pwr_q        <= pwr_d;
      div_q        <= div_d;
    end
  end

  // ********************************************************
  // engine hookup
  // ********************************************************
  assign sar.start   = go;
  assign sar.cmp     = cmp_in;
  assign sar.step_en = (st_q == scs_pkg::SCS_CONV) &&
                       (div_q == 4'(STEP_DIV - 1));

  scs_sar_engine u_engine (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .sar     (sar.engine)
  );

  // ********************************************************
  // register port
  // ********************************************************
  // unmapped reads return zero; data stand one cycle only
  always_comb begin
    ctrl_acq_d = ctrl_acq_q;
    rd_d       = 32'h0000_0000;
    if (reg_wr_en && reg_addr == scs_pkg::REG_CTRL) begin
      ctrl_acq_d = reg_wr_data[7:0];
    end
    if (reg_rd_en) begin
      unique case (reg_addr)
        scs_pkg::REG_CTRL:   rd_d[7:0]  = ctrl_acq_q;
        scs_pkg::REG_STATUS: begin
          rd_d[scs_pkg::ST_BUSY_BIT]         = busy_q;
          rd_d[scs_pkg::ST_STATE_LSB +: 2]   = st_q;
          rd_d[scs_pkg::ST_STALE_BIT]        = stale_q;
          rd_d[scs_pkg::ST_PD_BIT]           = power_down_in;
        end
        scs_pkg::REG_RESULT: rd_d[15:0] = data_q;
        default:             rd_d       = 32'h0000_0000;
      endcase
    end
  end

  // register state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_acq_q <= scs_pkg::CTRL_ACQ_RST;
      rd_q       <= 32'h0000_0000;
    end else begin
      ctrl_acq_q <= ctrl_acq_d;
      rd_q       <= rd_d;
    end
  end

  // outputs, all from flip-flops
  assign busy            = busy_q;
  assign sample_hold     = busy_q;       // hold while converting
  assign data_out        = data_q;
  assign data_stale      = stale_q;
  assign analog_power_en = pwr_q;
  assign dac_trial       = sar.trial;
  assign reg_rd_data     = rd_q;

  // ********************************************************
  // checks
  // ********************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_taken;
    ##1 busy_q && st_q == scs_pkg::SCS_CONV;
  endsequence

  property p_start_holds;
    (st_q == scs_pkg::SCS_IDLE && fall && !power_down_in && !reset_in)
      |-> s_taken;
  endproperty
  a_start_holds: assert property (p_start_holds)
    else $error("falling start edge did not begin a conversion");

  property p_busy_falls_on_result;
    $fell(busy_q) && !$past(reset_in) |-> $past(sar.done);
  endproperty
  a_busy_falls_on_result: assert property (p_busy_falls_on_result)
    else $error("busy fell without a finished search");

  property p_coded_result;
    $fell(busy_q) && !$past(reset_in) |->
      data_q == (sar.result ^ (16'h8000 & {16{~$past(output_coding_select)}}));
  endproperty
  a_coded_result: assert property (p_coded_result)
    else $error("result coding does not match the select");

  // a start edge in conversion must not relaunch the engine either
  property p_ignore_busy;
    (st_q == scs_pkg::SCS_CONV && !sar.done && !reset_in)
      |-> !sar.start ##1 (st_q == scs_pkg::SCS_CONV && busy_q);
  endproperty
  a_ignore_busy: assert property (p_ignore_busy)
    else $error("conversion disturbed while busy");

  // power-down must hold the sequencer parked, whatever the start pin does
  property p_pd_inhibit;
    (st_q == scs_pkg::SCS_PDOWN && power_down_in && !reset_in)
      |=> st_q == scs_pkg::SCS_PDOWN && !busy_q;
  endproperty
  a_pd_inhibit: assert property (p_pd_inhibit)
    else $error("conversion ran during power-down");

  property p_reset_abort;
    reset_in |=> st_q == scs_pkg::SCS_IDLE && !busy_q;
  endproperty
  a_reset_abort: assert property (p_reset_abort)
    else $error("reset input did not abort");

  property p_burst_retrigger;
    (st_q == scs_pkg::SCS_ACQ && burst && acq_q == 8'h00 &&
     !convert_start_n && !power_down_in && !reset_in) |-> s_taken;
  endproperty
  a_burst_retrigger: assert property (p_burst_retrigger)
    else $error("held start did not re-trigger in burst mode");

endmodule // scs_sequencer

// *** bench/scs_afe_model.sv ***
// front end model: holds the input level and answers each trial
`timescale 1ns/1ps
module scs_afe_model (
  // clock
  input  wire logic               ref_clk,
  // sequencer side
  input  wire logic               sample_hold,
  input  wire logic [15:0]        dac_trial,
  output logic                    cmp_in,
  // test level, below zero underrange, above 16'hffff overrange
  input  wire logic signed [17:0] level
);
  logic signed [17:0] held;

  // track while acquiring, freeze once the sequencer holds
  always @(posedge ref_clk) begin
    if (!sample_hold) begin
      held <= level;
    end
  end

  // saturation falls out of the compare, no special case
  assign cmp_in = (held >= $signed({2'b00, dac_trial}));
endmodule // scs_afe_model

// *** bench/tb_top.sv ***
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_top;
  // ********
  // signals
  // ********
  logic               ref_clk;
  logic               rst_n;
  logic               convert_start_n;
  logic               reset_in;
  logic               power_down_in;
  logic               output_coding_select;
  logic               mode_fast_sel;
  logic               mode_burst_sel;
  logic               cmp_in;
  logic [15:0]        dac_trial;
  logic               sample_hold;
  logic               analog_power_en;
  logic               busy;
  logic [15:0]        data_out;
  logic               data_stale;
  logic [3:0]         reg_addr;
  logic [31:0]        reg_wr_data;
  logic               reg_wr_en;
  logic               reg_rd_en;
  logic [31:0]        reg_rd_data;
  logic signed [17:0] level;
  int                 error_cnt;
  int                 checks;
  int                 n;
  int                 k;
  logic signed [17:0] lvls [0:6] = '{18'sh3ffff, 18'sh00000, 18'sh08000,
    18'sh07fff, 18'sh01234, 18'sh0ffff, 18'sh10000};

  // ********
  // design and front end
  // ********
  // short gap limit keeps the stale scenario brief
  scs_sequencer #(.GAP_LIMIT_CYC(50), .STEP_DIV(1)) scs_sequencer_i (
    .ref_clk, .rst_n, .convert_start_n, .reset_in, .power_down_in,
    .output_coding_select, .mode_fast_sel, .mode_burst_sel, .cmp_in,
    .dac_trial, .sample_hold, .analog_power_en, .busy, .data_out,
    .data_stale, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en,
    .reg_rd_data);
  scs_afe_model scs_afe_model_i (
    .ref_clk, .sample_hold, .dac_trial, .cmp_in, .level);

  // 100 ns period
  always #50 ref_clk = ~ref_clk;

  // ********
  // tasks
  // ********
  task automatic stop_test();
    $display("error_cnt %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr    <= a;
    reg_wr_data <= d;
    reg_wr_en   <= 1'b1;
    @(posedge ref_clk);
    reg_wr_en   <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input string what,
                        input logic [31:0] exp);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_rd_en <= 1'b1;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    #1;
    chk(what, exp, reg_rd_data);
  endtask

  // expected code: saturate, then flip the msb for twos complement
  function automatic logic [15:0] code_of(input logic signed [17:0] lv,
                                          input logic ob);
    logic [15:0] s;
    s = (lv < 0) ? 16'h0000 : (lv > 18'sh0ffff) ? 16'hffff : lv[15:0];
    return ob ? s : (s ^ 16'h8000);
  endfunction

  // mid: 1 extra start edge and input change, 2 power-down,
  // 3 abort, 5 start held low; exp_n 0 means start must be ignored
  task automatic convert(input logic signed [17:0] lv, input int mid,
                         input int exp_n, input logic [15:0] exp_code,
                         input logic exp_stale);
    level = lv;
    @(posedge ref_clk);
    convert_start_n <= 1'b0;
    @(posedge ref_clk);
    if (mid != 5) begin
      convert_start_n <= 1'b1;
    end
    #1;
    for (k = 0; k < 4 && busy !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    if (exp_n == 0) begin
      chk("busy ignored", 32'h0, {31'h0, busy});
      return;
    end
    if (busy !== 1'b1) begin
      chk("busy rise", 32'h1, {31'h0, busy});
      return;
    end
    chk("hold", 32'h1, {31'h0, sample_hold});
    chk("first trial", 32'h8000, {16'h0, dac_trial});
    n = 0;
    do begin
      n++;
      @(posedge ref_clk);
      if (mid == 1 && n == 2) level = 18'sh00003;
      if (mid == 1 && n == 4) convert_start_n <= 1'b0;
      if (mid == 1 && n == 6) convert_start_n <= 1'b1;
      if (mid == 2 && n == 3) power_down_in <= 1'b1;
      if (mid == 3 && n == 5) reset_in <= 1'b1;
      #1;
    end while (busy === 1'b1 && n < 40);
    if (mid == 3) begin
      @(posedge ref_clk);
      reset_in <= 1'b0;
      #1;
    end
    chk("hold release", 32'h0, {31'h0, sample_hold});
    chk("busy cycles", 32'(exp_n), 32'(n));
    chk("data_out", {16'h0, exp_code}, {16'h0, data_out});
    chk("data_stale", {31'h0, exp_stale}, {31'h0, data_stale});
  endtask

  // ********
  // main sequence
  // ********
  initial begin
    ref_clk              = 1'b0;
    rst_n                = 1'b0;
    convert_start_n      = 1'b1;
    reset_in             = 1'b0;
    power_down_in        = 1'b0;
    output_coding_select = 1'b1;
    mode_fast_sel        = 1'b0;
    mode_burst_sel       = 1'b0;
    reg_addr             = 4'h0;
    reg_wr_data          = 32'h0;
    reg_wr_en            = 1'b0;
    reg_rd_en            = 1'b0;
    level                = 18'sh00000;
    error_cnt            = 0;
    checks               = 0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("busy reset", 32'h0, {31'h0, busy});
    chk("power up", 32'h1, {31'h0, analog_power_en});
    // registers: reset value, unmapped, read-only result
    reg_rd(scs_pkg::REG_CTRL, "ctrl reset", 32'h1);
    reg_rd(4'hc, "unmapped", 32'h0);
    reg_wr(scs_pkg::REG_RESULT, 32'h1234);
    reg_rd(scs_pkg::REG_RESULT, "result ro", 32'h0);
    // every level in both codings, extremes saturate
    for (int ob = 1; ob >= 0; ob--) begin
      for (int i = 0; i < 7; i++) begin
        @(posedge ref_clk);
        output_coding_select <= ob[0];
        convert(lvls[i], 0, 17,
                code_of(lvls[i], ob[0]), 1'b0);
        reg_rd(scs_pkg::REG_RESULT, "result",
               {16'h0, code_of(lvls[i], ob[0])});
      end
    end
    @(posedge ref_clk);
    output_coding_select <= 1'b1;
    // input moves and a start edge arrives mid-conversion
    convert(18'sh09c40, 1, 17, 16'h9c40, 1'b0);
    // abort keeps the last result
    convert(18'sh00064, 3, 6, 16'h9c40, 1'b0);
    convert(18'sh00005, 0, 17, 16'h0005, 1'b0);
    repeat (6) @(posedge ref_clk);
    reg_rd(scs_pkg::REG_STATUS, "status idle", 32'h0);
    // power-down lets the running conversion end, then blocks
    convert(18'sh00007, 2, 17, 16'h0007, 1'b0);
    repeat (4) @(posedge ref_clk);
    convert(18'sh00009, 0, 0, 16'h0007, 1'b0);
    chk("pd power", 32'h0, {31'h0, analog_power_en});
    reg_rd(scs_pkg::REG_STATUS, "status pd", 32'h14);
    @(posedge ref_clk);
    power_down_in <= 1'b0;
    repeat (60) @(posedge ref_clk);
    // fast mode: first and late results flagged, close ones clean
    mode_fast_sel <= 1'b1;
    convert(18'sh00100, 0, 17, 16'h0100, 1'b1);
    convert(18'sh00200, 0, 17, 16'h0200, 1'b0);
    repeat (60) @(posedge ref_clk);
    convert(18'sh00300, 0, 17, 16'h0300, 1'b1);
    repeat (4) @(posedge ref_clk);
    reg_rd(scs_pkg::REG_STATUS, "status stale", 32'h8);
    @(posedge ref_clk);
    mode_fast_sel <= 1'b0;
    // burst: long acquisition, start held low relaunches at its end
    mode_burst_sel <= 1'b1;
    reg_wr(scs_pkg::REG_CTRL, 32'h10);
    reg_rd(scs_pkg::REG_CTRL, "ctrl rw", 32'h10);
    repeat (20) @(posedge ref_clk);
    #1;
    chk("burst idle power", 32'h0, {31'h0, analog_power_en});
    convert(18'sh00032, 5, 17, 16'h0032, 1'b0);
    for (k = 0; k < 40 && busy !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("burst relaunch", 32'd17, (busy === 1'b1) ? 32'(k) : 32'h0);
    @(posedge ref_clk);
    convert_start_n <= 1'b1;
    for (k = 0; k < 40 && busy !== 1'b0; k++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("burst done", 32'h0, {31'h0, busy});
    repeat (30) @(posedge ref_clk);
    #1;
    chk("burst power", 32'h0, {31'h0, analog_power_en});
    stop_test();
  end
endmodule // tb_top
